// ---- rtl/c1pdn_regs.vh ----
// register map, field layout, reset values and timing counts of the standalone node
`ifndef C1PDN_REGS_VH
`define C1PDN_REGS_VH
`define C1PDN_OFS_SCR 8'h00
`define C1PDN_OFS_CTRL 8'h04
`define C1PDN_OFS_MASK 8'h08
`define C1PDN_OFS_FDATA 8'h0C
`define C1PDN_OFS_STAT 8'h10
`define C1PDN_SEL_SCR 3'd0
`define C1PDN_SEL_CTRL 3'd1
`define C1PDN_SEL_MASK 3'd2
`define C1PDN_SEL_FDATA 3'd3
`define C1PDN_SEL_STAT 3'd4
`define C1PDN_SEL_NONE 3'd7
`define C1PDN_CTRL_SWAP 0
`define C1PDN_CTRL_FORCE 1
`define C1PDN_CTRL_STANDALONE 2
`define C1PDN_CTRL_RESET 16'h0004
`define C1PDN_SCR_TOP_RESET 4'h0
`define C1PDN_SCR_LOW_RESET 8'h43
`define C1PDN_RESP_OKAY 2'b00
`define C1PDN_RESP_SLVERR 2'b10
`define C1PDN_STATUS_FCODE 4'hF
`define C1PDN_PD_FCODE_MAX 4'h4
`define C1PDN_GROUP_FCODE 4'h4
`define C1PDN_DEVICE_TYPE 4'hF
`define C1PDN_PORT_SYNC 4'hF
`define C1PDN_ACC_LIMIT 64
`define C1PDN_CLK_NS 10
`define C1PDN_STROBE_NS 125
`define C1PDN_STROBE_CYC ((`C1PDN_STROBE_NS + `C1PDN_CLK_NS - 1) / `C1PDN_CLK_NS)
`endif

// ---- rtl/c1pdn_bus_mux.v ----
// internal bus multiplexer: byte swap and word forcing network
`timescale 1ns/100ps
`default_nettype none
module c1pdn_bus_mux (
  // word in and steering
  input wire [15:0] din,
  input wire swap,
  input wire [15:0] mask,
  input wire [15:0] force_data,
  // word out
  output wire [15:0] dout
);
  wire [15:0] swapped;
  assign swapped = swap ? {din[7:0], din[15:8]} : din; // [RQ3]
  // a set mask bit replaces the data bit by the force bit
  assign dout = (swapped & ~mask) | (force_data & mask); // [RQ2]
endmodule // c1pdn_bus_mux
`default_nettype wire

// ---- rtl/c1pdn_node.v ----
// standalone process-data node: port engine, status report, peripheral bus, register slave
//
// Summary of operation
// RQ1: buffer enables held high, direction held low
// RQ2: forcing applies mask and data word-wise
// RQ3: multiplexer can swap word bytes
// RQ4: sixteen ports, codes 0-4, no forcing
// RQ5: code 15 answers self-made status word
// RQ6: low four node address bits forced zero
// RQ7: erroneous reception skips all peripheral writes
// RQ8: match address 11..4, port from 3..0
// RQ9: port 15 reception pulses strobe 125 ns
// RQ10: codes 1-4 merge 2,4,8,16 ports
// RQ11: master sends only group-aligned port addresses
// RQ12: ports 0-7 source, 8-15 sink, code 4 all source
// RQ13: no error, timeout, ack or page bits
// RQ14: process-data control word from frame code
// RQ15: status control word: ones, source, one word
// RQ16: status word layout of type, flags, pins
// RQ17: active-line flag from decoder after switch
// RQ18: disturbed flag captured before it is cleared
// RQ19: timeout and waitstates from pins, rest zero
// RQ20: operating level starts at three
// RQ21: decoded active-low selects, upper address high
// RQ22: not-ready direct, other pins latched until report
// RQ23: waitstates 0-3, ready extends to 64 cycles
// RQ24: single clock, synchronous reset clears flags, strobe
`timescale 1ns/100ps
`default_nettype none
`include "c1pdn_regs.vh"
module c1pdn_node #(
  parameter ACC_LIMIT = `C1PDN_ACC_LIMIT
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // master frame and received data from the line decoder
  input wire mf_valid,
  input wire [3:0] mf_fcode,
  input wire [11:0] mf_addr,
  input wire rx_valid,
  input wire [15:0] rx_data,
  input wire rx_end,
  input wire rx_err,
  input wire active_line_flag,
  input wire line_disturbed_flag,
  output reg line_disturbed_clr,
  // slave frame words to the encoder
  output reg tx_valid,
  output reg [15:0] tx_data,
  output reg tx_last,
  output reg [15:0] port_control_word,
  // strap and user flag pins
  input wire [11:4] node_address_pins,
  input wire [1:0] waitstate_pins,
  input wire [1:0] reply_timeout_pins,
  input wire not_ready_pin,
  input wire extended_reply_pin,
  input wire node_disturbance_pin,
  input wire system_disturbance_pin,
  // peripheral bus
  output reg [15:0] cs_n,
  output reg [2:0] addr_hi_n,
  output reg rd_n,
  output reg wr_n,
  input wire memory_ready_n,
  input wire [15:0] pdata_in,
  output reg [15:0] pdata_out,
  output reg pdata_oe,
  output reg a_en_n,
  output reg d_en_n,
  output reg dir,
  output reg strobe_n
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_ACC = 3'd2;
  localparam ST_GAP = 3'd3;
  localparam ST_TX = 3'd4;
  localparam integer ACC_NUM = ACC_LIMIT - 1;
  localparam integer STROBE_NUM = `C1PDN_STROBE_CYC;
  // counters are sized for the documented limits; cut on purpose
  localparam [6:0] ACC_LAST = ACC_NUM[6:0];
  localparam [3:0] STROBE_CYC = STROBE_NUM[3:0];

  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `C1PDN_OFS_SCR: reg_sel = `C1PDN_SEL_SCR;
        `C1PDN_OFS_CTRL: reg_sel = `C1PDN_SEL_CTRL;
        `C1PDN_OFS_MASK: reg_sel = `C1PDN_SEL_MASK;
        `C1PDN_OFS_FDATA: reg_sel = `C1PDN_SEL_FDATA;
        `C1PDN_OFS_STAT: reg_sel = `C1PDN_SEL_STAT;
        default: reg_sel = `C1PDN_SEL_NONE;
      endcase
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] d;
    input [1:0] strb;
    begin
      merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // two-stage synchronisers for every pin
  reg [33:0] sync1_reg;
  reg [33:0] sync2_reg;
  wire [15:0] pdata_s = sync2_reg[15:0];
  wire ready_n_s = sync2_reg[16];
  wire [7:0] naddr_s = sync2_reg[24:17];
  wire [1:0] ws_s = sync2_reg[26:25];
  wire [1:0] tmo_s = sync2_reg[28:27];
  wire dnr_s = sync2_reg[29];
  wire erd_s = sync2_reg[30];
  wire sdd_s = sync2_reg[31];
  wire ssd_s = sync2_reg[32];

  reg [15:0] scr_reg;
  reg scr_loaded_reg;
  reg [15:0] ctrl_reg;
  reg [15:0] mask_reg;
  reg [15:0] fdata_reg;
  reg [15:0] status_word_reg;
  reg erd_l_reg;
  reg sdd_l_reg;
  reg ssd_l_reg;
  reg flags_clr_reg;
  reg [2:0] state_reg;
  reg [3:0] base_reg;
  reg [4:0] nwords_reg;
  reg [4:0] idx_reg;
  reg src_reg;
  reg [6:0] cnt_reg;
  reg [3:0] strobe_cnt_reg;
  reg [15:0] buf_mem [0:15];
  reg [7:0] awaddr_reg;
  reg aw_have_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg w_have_reg;

  wire [11:0] node_address = {naddr_s, 4'h0}; // [RQ6]
  wire addr_match = (mf_addr[11:4] == node_address[11:4]); // [RQ8]
  wire [4:0] mf_n = 5'd1 << mf_fcode[2:0]; // [RQ10]
  wire [3:0] mf_base = mf_addr[3:0] & ~(mf_n[3:0] - 4'd1);
  wire mf_src = (mf_fcode == `C1PDN_GROUP_FCODE) || !mf_base[3]; // [RQ12]
  wire [1:0] ws_cfg = scr_reg[9:8];
  wire [3:0] cur_port = base_reg + idx_reg[3:0];
  wire acc_done = (cnt_reg >= {5'd0, ws_cfg}) && (!ready_n_s || cnt_reg == ACC_LAST); // [RQ23]
  wire last_word = (idx_reg + 5'd1 == nwords_reg);
  // standalone ignores the force registers
  wire force_on = ctrl_reg[`C1PDN_CTRL_FORCE] && !ctrl_reg[`C1PDN_CTRL_STANDALONE]; // [RQ4]
  wire [15:0] mux_in = (state_reg == ST_ACC) ? pdata_s : rx_data;
  wire [15:0] mux_out;
  // status word: type, reserved, line flags, latched and direct pins
  wire [15:0] status_word = {`C1PDN_DEVICE_TYPE, 4'h0, active_line_flag, // [RQ16] [RQ17]
    line_disturbed_flag, ssd_l_reg, sdd_l_reg, erd_l_reg, 1'b0, dnr_s, 1'b0}; // [RQ18]

  c1pdn_bus_mux u_mux (
    .din(mux_in),
    .swap(ctrl_reg[`C1PDN_CTRL_SWAP]),
    .mask(force_on ? mask_reg : 16'h0000),
    .force_data(fdata_reg),
    .dout(mux_out)
  );

  always @(posedge aclk) begin
    sync1_reg <= {1'b0, system_disturbance_pin, node_disturbance_pin, extended_reply_pin,
      not_ready_pin, reply_timeout_pins, waitstate_pins, node_address_pins,
      memory_ready_n, pdata_in};
    sync2_reg <= sync1_reg;
  end

  // timeout and waitstate straps are taken once, on the first clock after reset is released
  always @(posedge aclk) begin
    if (!aresetn) begin
      scr_reg <= {`C1PDN_SCR_TOP_RESET, 4'h0, `C1PDN_SCR_LOW_RESET}; // [RQ20]
      scr_loaded_reg <= 1'b0;
    end else if (!scr_loaded_reg) begin
      scr_loaded_reg <= 1'b1;
      // mask, quiet and master capable stay zero
      scr_reg <= {`C1PDN_SCR_TOP_RESET, tmo_s, ws_s, `C1PDN_SCR_LOW_RESET}; // [RQ19]
    end
  end

  // latched user flags, set wins over clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      erd_l_reg <= 1'b0; // [RQ24]
      sdd_l_reg <= 1'b0;
      ssd_l_reg <= 1'b0;
    end else begin
      erd_l_reg <= (erd_l_reg & ~flags_clr_reg) | erd_s; // [RQ22]
      sdd_l_reg <= (sdd_l_reg & ~flags_clr_reg) | sdd_s;
      ssd_l_reg <= (ssd_l_reg & ~flags_clr_reg) | ssd_s;
    end
  end

  task start_acc;
    input [3:0] port;
    begin
      cs_n <= ~(16'h0001 << port); // [RQ21]
      rd_n <= ~src_reg;
      wr_n <= src_reg;
      pdata_oe <= !src_reg;
      pdata_out <= buf_mem[port - base_reg];
      cnt_reg <= 7'd0;
      state_reg <= ST_ACC;
    end
  endtask

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      base_reg <= 4'h0;
      nwords_reg <= 5'd0;
      idx_reg <= 5'd0;
      src_reg <= 1'b0;
      cnt_reg <= 7'd0;
      strobe_cnt_reg <= 4'h0;
      strobe_n <= 1'b1; // [RQ24]
      cs_n <= 16'hFFFF;
      addr_hi_n <= 3'b111;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      pdata_out <= 16'h0000;
      pdata_oe <= 1'b0;
      a_en_n <= 1'b1;
      d_en_n <= 1'b1;
      dir <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 16'h0000;
      tx_last <= 1'b0;
      port_control_word <= 16'h0000;
      status_word_reg <= 16'h0000;
      flags_clr_reg <= 1'b0;
      line_disturbed_clr <= 1'b0;
    end else begin
      a_en_n <= 1'b1; // [RQ1]
      d_en_n <= 1'b1;
      dir <= 1'b0;
      addr_hi_n <= 3'b111; // [RQ21]
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      flags_clr_reg <= 1'b0;
      line_disturbed_clr <= 1'b0;
      if (strobe_cnt_reg != 4'h0) begin
        strobe_cnt_reg <= strobe_cnt_reg - 4'h1;
        strobe_n <= (strobe_cnt_reg == 4'h1);
      end
      case (state_reg)
        ST_IDLE: begin
          if (mf_valid && mf_fcode == `C1PDN_STATUS_FCODE && mf_addr == node_address) begin
            // report sent at once; flags sampled before their clears land
            tx_valid <= 1'b1; // [RQ5]
            tx_data <= status_word; // [RQ18]
            tx_last <= 1'b1;
            status_word_reg <= status_word;
            port_control_word <= {`C1PDN_STATUS_FCODE, 12'h802}; // [RQ15]
            flags_clr_reg <= 1'b1; // [RQ22]
            line_disturbed_clr <= 1'b1; // [RQ18]
          end else if (mf_valid && addr_match && mf_fcode <= `C1PDN_PD_FCODE_MAX) begin
            // no error, ack or page bits exist in this word
            port_control_word <= {mf_fcode, mf_src, !mf_src, 10'h002}; // [RQ14] [RQ13]
            base_reg <= mf_base; // [RQ8]
            nwords_reg <= mf_n; // [RQ4]
            src_reg <= mf_src; // [RQ12]
            idx_reg <= 5'd0;
            if (mf_src) begin
              cs_n <= ~(16'h0001 << mf_base); // [RQ21]
              rd_n <= 1'b0;
              cnt_reg <= 7'd0;
              state_reg <= ST_ACC;
            end else begin
              state_reg <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rx_valid && idx_reg < nwords_reg) begin
            buf_mem[idx_reg[3:0]] <= mux_out; // [RQ2]
            idx_reg <= idx_reg + 5'd1;
          end
          if (rx_end) begin
            idx_reg <= 5'd0;
            // bad or short frames leave peripherals untouched
            if (rx_err || idx_reg != nwords_reg)
              state_reg <= ST_IDLE; // [RQ7]
            else
              start_acc(base_reg);
          end
        end
        ST_ACC: begin
          cnt_reg <= cnt_reg + 7'd1;
          if (acc_done) begin
            if (src_reg)
              buf_mem[idx_reg[3:0]] <= mux_out;
            cs_n <= 16'hFFFF;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            pdata_oe <= 1'b0;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (!last_word) begin
            idx_reg <= idx_reg + 5'd1;
            start_acc(cur_port + 4'h1);
          end else if (src_reg) begin
            idx_reg <= 5'd0;
            state_reg <= ST_TX;
          end else begin
            if (cur_port == `C1PDN_PORT_SYNC) begin
              strobe_n <= 1'b0; // [RQ9]
              strobe_cnt_reg <= STROBE_CYC;
            end
            state_reg <= ST_IDLE;
          end
        end
        ST_TX: begin
          tx_valid <= 1'b1;
          tx_data <= buf_mem[idx_reg[3:0]];
          tx_last <= last_word;
          idx_reg <= idx_reg + 5'd1;
          if (last_word)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // register slave: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `C1PDN_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `C1PDN_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      ctrl_reg <= `C1PDN_CTRL_RESET;
      mask_reg <= 16'h0000;
      fdata_reg <= 16'h0000;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `C1PDN_RESP_OKAY;
        case (reg_sel(awaddr_reg))
          `C1PDN_SEL_CTRL: ctrl_reg <= merge(ctrl_reg, wdata_reg[15:0], wstrb_reg[1:0]) & 16'h0007;
          `C1PDN_SEL_MASK: mask_reg <= merge(mask_reg, wdata_reg[15:0], wstrb_reg[1:0]);
          `C1PDN_SEL_FDATA: fdata_reg <= merge(fdata_reg, wdata_reg[15:0], wstrb_reg[1:0]);
          `C1PDN_SEL_SCR, `C1PDN_SEL_STAT: s_axi_bresp <= `C1PDN_RESP_OKAY;
          default: s_axi_bresp <= `C1PDN_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `C1PDN_RESP_OKAY;
        case (reg_sel(s_axi_araddr))
          `C1PDN_SEL_SCR: s_axi_rdata <= {16'h0000, scr_reg};
          `C1PDN_SEL_CTRL: s_axi_rdata <= {16'h0000, ctrl_reg};
          `C1PDN_SEL_MASK: s_axi_rdata <= {16'h0000, mask_reg};
          `C1PDN_SEL_FDATA: s_axi_rdata <= {16'h0000, fdata_reg};
          `C1PDN_SEL_STAT: s_axi_rdata <= {13'h0000, state_reg, status_word_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `C1PDN_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // c1pdn_node
`default_nettype wire

// ---- bench/c1pdn_node_properties.sv ----
// port-level assertions for the standalone process-data node
`timescale 1ns/100ps
`default_nettype none
`include "c1pdn_regs.vh"
module c1pdn_node_checker #(
  parameter ACC_LIMIT = 64
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // slave frame output
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [15:0] tx_data,
  input wire logic [15:0] port_control_word,
  input wire logic line_disturbed_clr,
  // peripheral bus
  input wire logic [15:0] cs_n,
  input wire logic [2:0] addr_hi_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic pdata_oe,
  input wire logic a_en_n,
  input wire logic d_en_n,
  input wire logic dir,
  input wire logic strobe_n
);
  logic [4:0] low_cnt;
  logic [7:0] rd_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // run lengths of strobe low and read low, in cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= 5'h0;
      rd_cnt <= 8'h0;
    end else begin
      low_cnt <= strobe_n ? 5'h0 : low_cnt + 5'h1;
      rd_cnt <= rd_n ? 8'h0 : rd_cnt + 8'h1;
    end
  end
  buf_idle_a: assert property (a_en_n && d_en_n && !dir)
    else $error("buffer control active");
  addr_high_a: assert property (addr_hi_n == 3'h7)
    else $error("upper address not high");
  one_select_a: assert property ((!rd_n || !wr_n) |-> $onehot(~cs_n))
    else $error("access without single select");
  strobe_len_a: assert property ($rose(strobe_n) |-> low_cnt == `C1PDN_STROBE_CYC)
    else $error("strobe width wrong");
  acc_limit_a: assert property (rd_cnt <= ACC_LIMIT)
    else $error("access longer than limit");
  status_word_a: assert property (tx_valid && port_control_word[15:12] == 4'hF |->
    tx_last && port_control_word == 16'hF802 && tx_data[15:8] == 8'hF0 && !tx_data[2]
    && !tx_data[0]) else $error("status report malformed");
  clr_report_a: assert property (line_disturbed_clr |-> tx_valid && port_control_word == 16'hF802)
    else $error("disturbed flag cleared outside report");
  pd_control_a: assert property (tx_valid && port_control_word[15:12] != 4'hF |->
    port_control_word[11:0] == 12'h802 && port_control_word[15:12] <= 4'h4)
    else $error("source control word wrong");
  sink_write_a: assert property (!wr_n |-> pdata_oe && port_control_word[11:0] == 12'h402
    && port_control_word[15:12] < 4'h4) else $error("write outside sink transfer");
  reset_quiet_a: assert property ($rose(aresetn) |-> strobe_n && &cs_n && !tx_valid)
    else $error("outputs active after reset");
  cover property (tx_valid && tx_last && port_control_word == 16'hF802);
  cover property ($rose(strobe_n));
  cover property (tx_valid && port_control_word == 16'h4802);
endmodule // c1pdn_node_checker
bind c1pdn_node c1pdn_node_checker #(.ACC_LIMIT(ACC_LIMIT)) u_chk (.aclk, .aresetn, .tx_valid,
  .tx_last, .tx_data, .port_control_word, .line_disturbed_clr, .cs_n, .addr_hi_n, .rd_n, .wr_n,
  .pdata_oe, .a_en_n, .d_en_n, .dir, .strobe_n);
`default_nettype wire

// ---- bench/c1pdn_periph_model.sv ----
// model of the simple peripheral ports behind the decoded selects
`timescale 1ns/100ps
`default_nettype none
module c1pdn_periph_model (
  // clock
  input wire logic aclk,
  // decoded peripheral bus
  input wire logic [15:0] cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [15:0] pdata_out,
  input wire logic pdata_oe,
  output logic [15:0] pdata_in,
  output logic memory_ready_n,
  // scenario control and observation
  input wire logic slow,
  output logic [7:0] wr_count
);
  logic [15:0] mem [16];
  logic [15:0] last;
  int sel;
  always_comb begin
    sel = -1;
    for (int i = 0; i < 16; i++) if (!cs_n[i]) sel = i;
  end
  // released bus shows the inverse of the last word, never a stale copy
  assign pdata_in = (sel >= 0 && !rd_n) ? mem[sel] : ~last;
  // a slow port holds ready high; the node has to end the access itself
  assign memory_ready_n = slow;
  initial begin
    wr_count = 8'h0;
    last = 16'h0;
    for (int i = 0; i < 16; i++) mem[i] = {12'hA5C, i[3:0]};
  end
  always @(posedge aclk) begin
    if (sel >= 0 && !rd_n) last <= mem[sel];
    if (sel >= 0 && !wr_n && pdata_oe) begin
      mem[sel] <= pdata_out;
      wr_count <= wr_count + 8'h1;
    end
  end
endmodule // c1pdn_periph_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the standalone process-data node
`timescale 1ns/100ps
`default_nettype none
`include "c1pdn_regs.vh"
module tb_top;
  localparam logic [7:0] NODE = 8'h3A;
  logic aclk, aresetn, slow, strobe_seen, tx_valid, tx_last;
  logic [7:0] s_axi_awaddr, s_axi_araddr, node_address_pins, wr_count;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb, mf_fcode;
  logic [1:0] s_axi_bresp, s_axi_rresp, waitstate_pins, reply_timeout_pins, resp;
  logic mf_valid, rx_valid, rx_end, rx_err, active_line_flag, line_disturbed_flag;
  logic line_disturbed_clr, not_ready_pin, extended_reply_pin, node_disturbance_pin;
  logic system_disturbance_pin, rd_n, wr_n, memory_ready_n, pdata_oe, a_en_n, d_en_n, dir;
  logic strobe_n;
  logic [11:0] mf_addr;
  logic [15:0] rx_data, tx_data, port_control_word, cs_n, pdata_in, pdata_out;
  logic [2:0] addr_hi_n;
  logic [15:0] txq [$];
  int failures, checks_done, cyc;

  c1pdn_node #(.ACC_LIMIT(8)) dut (.*);
  c1pdn_periph_model peri (.*);

  initial aclk = 1'h0;
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_valid === 1'h1) txq.push_back(tx_data);
    if (strobe_n === 1'h0) strobe_seen <= 1'h1;
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end

  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task eq(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [15:0] pat(input int i);
    return {12'hA5C, i[3:0]};
  endfunction
  task ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task frame(input logic [3:0] fc, input logic [11:0] a);
    ticks(2);
    txq.delete();
    mf_valid <= 1'h1;
    mf_fcode <= fc;
    mf_addr <= a;
    @(posedge aclk);
    mf_valid <= 1'h0;
  endtask
  task wait_tx(input int n);
    for (int i = 0; i < 400 && txq.size() < n; i++) @(posedge aclk);
  endtask
  task sink(input logic [3:0] fc, input logic [3:0] port, input int n, input logic err);
    frame(fc, {NODE, port});
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rx_valid <= 1'h1;
      rx_data <= 16'h5A00 + 16'(i);
    end
    @(posedge aclk);
    rx_valid <= 1'h0;
    rx_end <= 1'h1;
    rx_err <= err;
    @(posedge aclk);
    rx_end <= 1'h0;
    rx_err <= 1'h0;
  endtask
  task poll(input logic [15:0] w);
    frame(4'hF, {NODE, 4'h0});
    wait_tx(1);
    eq(txq[0], w);
    eq(port_control_word, 16'hF802);
  endtask

  task t_reset;
    eq({a_en_n, d_en_n, dir, addr_hi_n}, 6'h37);
    eq({strobe_n, cs_n}, 17'h1_FFFF);
  endtask
  task t_regs;
    wr(`C1PDN_OFS_SCR, 32'h0000_0000, resp);
    rd(`C1PDN_OFS_SCR, rdat, resp);
    eq(rdat[15:0], 16'h0743);
    rd(8'h20, rdat, resp);
    eq(resp, `C1PDN_RESP_SLVERR);
    wr(8'h20, 32'h0000_FFFF, resp);
    eq(resp, `C1PDN_RESP_SLVERR);
  endtask
  task t_status;
    @(posedge aclk);
    extended_reply_pin <= 1'h1;
    system_disturbance_pin <= 1'h1;
    ticks(4);
    extended_reply_pin <= 1'h0;
    system_disturbance_pin <= 1'h0;
    ticks(4);
    poll(16'hF0FA);
    active_line_flag <= 1'h0;
    line_disturbed_flag <= 1'h0;
    not_ready_pin <= 1'h0;
    ticks(4);
    poll(16'hF010);
  endtask
  task t_source;
    for (int fc = 0; fc < 5; fc++) begin
      frame(fc[3:0], {NODE, 4'h0});
      wait_tx(1 << fc);
      eq(txq.size(), 1 << fc);
      for (int i = 0; i < (1 << fc); i++) eq(txq[i], pat(i));
      eq(port_control_word, {fc[3:0], 12'h802});
    end
  endtask
  task t_swap;
    wr(`C1PDN_OFS_MASK, 32'h0000_FFFF, resp);
    wr(`C1PDN_OFS_FDATA, 32'h0000_0000, resp);
    wr(`C1PDN_OFS_CTRL, 32'h0000_0005, resp);
    frame(4'h0, {NODE, 4'h5});
    wait_tx(1);
    eq(txq[0], 16'hC5A5);
    wr(`C1PDN_OFS_CTRL, 32'h0000_0004, resp);
  endtask
  task t_sink;
    strobe_seen = 1'h0;
    sink(4'h1, 4'hE, 2, 1'h0);
    for (int i = 0; i < 300 && !strobe_seen; i++) @(posedge aclk);
    eq(strobe_seen, 1'h1);
    eq(peri.mem[14], 16'h5A00);
    eq(peri.mem[15], 16'h5A01);
    eq(port_control_word, 16'h1402);
  endtask
  task t_error;
    logic [7:0] wc;
    wc = wr_count;
    sink(4'h0, 4'h9, 1, 1'h1);
    ticks(40);
    eq(wr_count, wc);
    eq(peri.mem[9], pat(9));
  endtask
  task t_miss;
    frame(4'h0, {8'h3B, 4'h1});
    ticks(40);
    eq(txq.size(), 0);
  endtask
  task t_slow;
    slow <= 1'h1;
    frame(4'h0, {NODE, 4'h1});
    wait_tx(1);
    eq(txq.size(), 1);
    slow <= 1'h0;
  endtask

  initial begin
    aresetn = 1'h0;
    slow = 1'h0;
    strobe_seen = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    {mf_valid, rx_valid, rx_end, rx_err, extended_reply_pin, system_disturbance_pin} = 6'h0;
    {mf_fcode, mf_addr, rx_data} = 32'h0;
    {active_line_flag, line_disturbed_flag, not_ready_pin, node_disturbance_pin} = 4'hF;
    node_address_pins = NODE;
    waitstate_pins = 2'h3;
    reply_timeout_pins = 2'h1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    ticks(3);
    t_reset;
    t_regs;
    t_status;
    t_source;
    t_swap;
    t_sink;
    t_error;
    t_miss;
    t_slow;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
